/* include/lca_pkg.sv */
// Purpose: shared constants and types for the logic and compare datapath slice
// Assumes: 8-bit operands, 32-bit APB data, one register per aligned word
// Notes: register offsets are byte addresses on paddr
package lca_pkg;

  localparam int unsigned DW = 8;
  localparam int unsigned AW = 8;

  // register byte offsets
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_IMM = 8'h04;
  localparam logic [7:0] OFS_MEM_IN = 8'h08;
  localparam logic [7:0] OFS_WORK = 8'h0c;
  localparam logic [7:0] OFS_PORT = 8'h10;
  localparam logic [7:0] OFS_FLAGS = 8'h14;
  localparam logic [7:0] OFS_MEM_OUT = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;

  // flag register bit positions
  localparam int unsigned FLG_ZERO = 0;
  localparam int unsigned FLG_CARRY = 1;
  localparam int unsigned FLG_NIBBLE = 2;
  localparam int unsigned FLG_WRAP = 3;

  // status register bit positions
  localparam int unsigned STS_BUSY = 0;
  localparam int unsigned STS_MEM_VALID = 1;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [3:0] RST_FLAGS = 4'h0;

  typedef enum logic [3:0] {
    OP_AND_AI = 4'h0, OP_AND_AM = 4'h1, OP_AND_MA = 4'h2,
    OP_OR_AI = 4'h3, OP_OR_AM = 4'h4, OP_OR_MA = 4'h5,
    OP_XOR_AI = 4'h6, OP_XOR_AM = 4'h7, OP_XOR_MA = 4'h8,
    OP_XOR_IOA = 4'h9, OP_NOT_A = 4'ha, OP_NOT_M = 4'hb,
    OP_NEG_A = 4'hc, OP_NEG_M = 4'hd, OP_CMP_AM = 4'he,
    OP_CMP_MA = 4'hf
  } lca_op_t;

  typedef enum logic [2:0] {
    LOP_AND = 3'h0, LOP_OR = 3'h1, LOP_XOR = 3'h2, LOP_NOT = 3'h3, LOP_NEG = 3'h4
  } lca_lop_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1
  } lca_st_t;

endpackage

/* include/lca_alu_if.sv */
// Purpose: operand and result bundle between the control logic and its two datapath units
// Assumes: all units sit on the same clock; the bundle is purely combinational
// Notes: the logic unit and the subtract unit both read opa and opb
`timescale 1ns/1ps
interface lca_alu_if;
  logic [7:0] opa;
  logic [7:0] opb;
  lca_pkg::lca_lop_t lop;
  logic [7:0] lres;
  logic [7:0] diff;
  logic borrow;
  logic nibble_borrow;
  logic signed_wrap;

  modport ctl_mp (output opa, output opb, output lop, input lres, input diff,
                  input borrow, input nibble_borrow, input signed_wrap);
  modport logic_mp (input opa, input opb, input lop, output lres);
  modport sub_mp (input opa, input opb, output diff, output borrow, output nibble_borrow,
                  output signed_wrap);
endinterface

/* hdl/lca_logic_unit.sv */
// Purpose: bitwise and/or/xor, one's complement and two's complement of a byte
// Assumes: not and neg act on opb alone
// Notes: purely combinational
`timescale 1ns/1ps
module lca_logic_unit (
  lca_alu_if.logic_mp alu
);

  always_comb begin
    case (alu.lop)
      lca_pkg::LOP_AND: alu.lres = alu.opa & alu.opb;
      lca_pkg::LOP_OR: alu.lres = alu.opa | alu.opb;
      lca_pkg::LOP_XOR: alu.lres = alu.opa ^ alu.opb;
      lca_pkg::LOP_NOT: alu.lres = ~alu.opb;
      // wraps modulo 256, so neg of 0x00 stays 0x00 and of 0x80 stays 0x80
      lca_pkg::LOP_NEG: alu.lres = 8'((~alu.opb) + 8'h01);
      default: alu.lres = alu.opb;
    endcase
  end

endmodule

/* hdl/lca_sub_flags.sv */
// Purpose: trial subtraction opa - opb with borrow, nibble borrow and signed wrap
// Assumes: carry means borrow, as on compare
// Notes: result is never stored by the caller for compares
`timescale 1ns/1ps
module lca_sub_flags (
  lca_alu_if.sub_mp alu
);

  logic [8:0] full;
  logic [4:0] low;

  always_comb begin
    full = {1'b0, alu.opa} - {1'b0, alu.opb};
    low = {1'b0, alu.opa[3:0]} - {1'b0, alu.opb[3:0]};
    alu.diff = full[7:0];
    alu.borrow = full[8];
    alu.nibble_borrow = low[4];
    // signed overflow: operands differ in sign and result sign differs from minuend
    alu.signed_wrap = (alu.opa[7] ^ alu.opb[7]) & (full[7] ^ alu.opa[7]);
  end

endmodule

/* hdl/lca_top.sv */
// Purpose: APB-controlled logic, complement and compare slice of a small 8-bit core
// Assumes: software loads operands, then writes an op code to the command register
// Notes: each command executes in the cycle after its write; answers have no wait state
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module lca_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] work_register,
  output logic [7:0] port_a_out_reg,
  output logic [3:0] flags,
  output logic [7:0] mem_wdata,
  output logic mem_we
);

  typedef struct packed {
    lca_pkg::lca_st_t st;
    lca_pkg::lca_op_t op;
    logic [7:0] imm;
    logic [7:0] mem_in;
    logic [7:0] work;
    logic [7:0] port;
    logic [7:0] mem_out;
    logic [3:0] flags;
    logic mem_valid;
    logic mem_we;
    logic rdy;
    logic err;
    logic [31:0] rdata;
  } lca_state_t;

  lca_state_t cur;
  lca_state_t next_cur;
  lca_alu_if alu ();

  logic setup_phase;
  logic wr_take;
  logic zero_res;
  logic zero_diff;
  logic dst_work;
  logic dst_mem;
  logic dst_port;
  logic upd_zero;
  logic upd_cmp;

  lca_logic_unit u_logic (
    .alu(alu)
  );

  lca_sub_flags u_sub (
    .alu(alu)
  );

  // operand routing for the op held in cur.op
  always_comb begin
    alu.opa = cur.work;
    alu.opb = cur.mem_in;
    alu.lop = lca_pkg::LOP_AND;
    case (cur.op)
      lca_pkg::OP_AND_AI: begin
        alu.opb = cur.imm;
      end
      lca_pkg::OP_AND_AM, lca_pkg::OP_AND_MA: begin
        alu.lop = lca_pkg::LOP_AND;
      end
      lca_pkg::OP_OR_AI: begin
        alu.opb = cur.imm;
        alu.lop = lca_pkg::LOP_OR;
      end
      lca_pkg::OP_OR_AM, lca_pkg::OP_OR_MA: begin
        alu.lop = lca_pkg::LOP_OR;
      end
      lca_pkg::OP_XOR_AI: begin
        alu.opb = cur.imm;
        alu.lop = lca_pkg::LOP_XOR;
      end
      lca_pkg::OP_XOR_AM, lca_pkg::OP_XOR_MA: begin
        alu.lop = lca_pkg::LOP_XOR;
      end
      lca_pkg::OP_XOR_IOA: begin
        alu.opb = cur.port;
        alu.lop = lca_pkg::LOP_XOR;
      end
      lca_pkg::OP_NOT_A: begin
        alu.opb = cur.work;
        alu.lop = lca_pkg::LOP_NOT;
      end
      lca_pkg::OP_NOT_M: begin
        alu.lop = lca_pkg::LOP_NOT;
      end
      lca_pkg::OP_NEG_A: begin
        alu.opb = cur.work;
        alu.lop = lca_pkg::LOP_NEG;
      end
      lca_pkg::OP_NEG_M: begin
        alu.lop = lca_pkg::LOP_NEG;
      end
      lca_pkg::OP_CMP_AM: begin
        alu.opa = cur.work;
        alu.opb = cur.mem_in;
      end
      lca_pkg::OP_CMP_MA: begin
        alu.opa = cur.mem_in;
        alu.opb = cur.work;
      end
      default: begin
        alu.opb = cur.mem_in;
      end
    endcase
  end

  assign setup_phase = psel & ~penable;
  assign wr_take = psel & penable & cur.rdy & pwrite & ~cur.err;
  assign zero_res = (alu.lres == lca_pkg::RST_BYTE);
  assign zero_diff = (alu.diff == lca_pkg::RST_BYTE);

  // destination and flag class of the held op, decoded once so that
  // the execute step can never give one op two destinations
  always_comb begin
    dst_work = 1'b0;
    dst_mem = 1'b0;
    dst_port = 1'b0;
    upd_zero = 1'b0;
    upd_cmp = 1'b0;
    case (cur.op)
      lca_pkg::OP_AND_AI,
      lca_pkg::OP_AND_AM,
      lca_pkg::OP_OR_AI,
      lca_pkg::OP_OR_AM,
      lca_pkg::OP_XOR_AI,
      lca_pkg::OP_XOR_AM,
      lca_pkg::OP_NOT_A,
      lca_pkg::OP_NEG_A: begin
        dst_work = 1'b1;
        upd_zero = 1'b1;
      end
      lca_pkg::OP_AND_MA,
      lca_pkg::OP_OR_MA,
      lca_pkg::OP_XOR_MA,
      lca_pkg::OP_NOT_M,
      lca_pkg::OP_NEG_M: begin
        dst_mem = 1'b1;
        upd_zero = 1'b1;
      end
      lca_pkg::OP_XOR_IOA: begin
        // the io form keeps every flag as it was
        dst_port = 1'b1;
      end
      lca_pkg::OP_CMP_AM,
      lca_pkg::OP_CMP_MA: begin
        upd_cmp = 1'b1;
      end
      default: begin
        upd_cmp = 1'b0;
      end
    endcase
  end

  always_comb begin
    next_cur = cur;
    next_cur.mem_we = 1'b0;
    next_cur.rdy = 1'b0;
    next_cur.err = 1'b0;

    // read data and error are captured in the setup cycle so the outputs come from flops
    if (setup_phase) begin
      next_cur.rdy = 1'b1;
      next_cur.rdata = 32'h0000_0000;
      if (!pwrite) begin
        case (paddr)
          lca_pkg::OFS_CMD: next_cur.rdata = {28'h000_0000, cur.op};
          lca_pkg::OFS_IMM: next_cur.rdata = {24'h00_0000, cur.imm};
          lca_pkg::OFS_MEM_IN: next_cur.rdata = {24'h00_0000, cur.mem_in};
          lca_pkg::OFS_WORK: next_cur.rdata = {24'h00_0000, cur.work};
          lca_pkg::OFS_PORT: next_cur.rdata = {24'h00_0000, cur.port};
          lca_pkg::OFS_FLAGS: next_cur.rdata = {28'h000_0000, cur.flags};
          lca_pkg::OFS_MEM_OUT: next_cur.rdata = {24'h00_0000, cur.mem_out};
          lca_pkg::OFS_STATUS: begin
            next_cur.rdata[lca_pkg::STS_BUSY] = (cur.st == lca_pkg::ST_EXEC);
            next_cur.rdata[lca_pkg::STS_MEM_VALID] = cur.mem_valid;
          end
          default: next_cur.err = 1'b1;
        endcase
      end else begin
        case (paddr)
          lca_pkg::OFS_CMD,
          lca_pkg::OFS_IMM,
          lca_pkg::OFS_MEM_IN,
          lca_pkg::OFS_WORK,
          lca_pkg::OFS_PORT,
          lca_pkg::OFS_FLAGS,
          lca_pkg::OFS_STATUS: next_cur.err = 1'b0;
          // the memory result is read-only
          default: next_cur.err = 1'b1;
        endcase
      end
    end

    if (wr_take) begin
      case (paddr)
        lca_pkg::OFS_CMD: begin
          next_cur.op = lca_pkg::lca_op_t'(pwdata[3:0]);
          next_cur.st = lca_pkg::ST_EXEC;
        end
        lca_pkg::OFS_IMM: next_cur.imm = pwdata[7:0];
        lca_pkg::OFS_MEM_IN: next_cur.mem_in = pwdata[7:0];
        lca_pkg::OFS_WORK: next_cur.work = pwdata[7:0];
        lca_pkg::OFS_PORT: next_cur.port = pwdata[7:0];
        lca_pkg::OFS_FLAGS: next_cur.flags = pwdata[3:0];
        lca_pkg::OFS_STATUS: begin
          if (pwdata[lca_pkg::STS_MEM_VALID]) begin
            next_cur.mem_valid = 1'b0;
          end
        end
        default: next_cur.err = 1'b0;
      endcase
    end

    // execution cannot meet a register write: an APB transfer spans at least two cycles
    case (cur.st)
      lca_pkg::ST_IDLE: begin
        next_cur.st = next_cur.st;
      end
      lca_pkg::ST_EXEC: begin
        next_cur.st = lca_pkg::ST_IDLE;
        if (dst_work) begin
          next_cur.work = alu.lres;
        end
        if (dst_mem) begin
          next_cur.mem_out = alu.lres;
          next_cur.mem_we = 1'b1;
          // set wins over a same-cycle clear from software
          next_cur.mem_valid = 1'b1;
        end
        if (dst_port) begin
          next_cur.port = alu.lres;
        end
        if (upd_zero) begin
          next_cur.flags[lca_pkg::FLG_ZERO] = zero_res;
        end
        if (upd_cmp) begin
          next_cur.flags[lca_pkg::FLG_ZERO] = zero_diff;
          next_cur.flags[lca_pkg::FLG_CARRY] = alu.borrow;
          next_cur.flags[lca_pkg::FLG_NIBBLE] = alu.nibble_borrow;
          next_cur.flags[lca_pkg::FLG_WRAP] = alu.signed_wrap;
        end
      end
      default: begin
        next_cur.st = lca_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur.st <= lca_pkg::ST_IDLE;
      cur.op <= lca_pkg::OP_AND_AI;
      cur.imm <= lca_pkg::RST_BYTE;
      cur.mem_in <= lca_pkg::RST_BYTE;
      cur.work <= lca_pkg::RST_BYTE;
      cur.port <= lca_pkg::RST_BYTE;
      cur.mem_out <= lca_pkg::RST_BYTE;
      cur.flags <= lca_pkg::RST_FLAGS;
      cur.mem_valid <= 1'b0;
      cur.mem_we <= 1'b0;
      cur.rdy <= 1'b0;
      cur.err <= 1'b0;
      cur.rdata <= 32'h0000_0000;
    end else begin
      cur <= next_cur;
    end
  end

  assign prdata = cur.rdata;
  assign pready = cur.rdy;
  assign pslverr = cur.err;
  assign work_register = cur.work;
  assign port_a_out_reg = cur.port;
  assign flags = cur.flags;
  assign mem_wdata = cur.mem_out;
  assign mem_we = cur.mem_we;

endmodule

/* tb/lca_top_monitor.sv */
// Purpose: port-level checker for the logic and compare slice
// Assumes: results land two edges after the accepted write to the command register
// Notes: watches only the top module's ports
`timescale 1ns/1ps
module lca_top_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] work_register,
  input wire logic [7:0] port_a_out_reg,
  input wire logic [3:0] flags,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we
);
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic cmd_ok;
  logic [3:0] op;
  // only an accepted command write starts an operation
  assign cmd_ok = psel & penable & pready & pwrite & ~pslverr & (paddr == lca_pkg::OFS_CMD);
  assign op = pwdata[3:0];
  setup_answer_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  unmapped_err_a: assert property (pready && paddr > 8'h1c |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  io_xor_a: assert property (cmd_ok && op == 4'h9 |-> ##2
    port_a_out_reg == $past(port_a_out_reg ^ work_register, 2) && flags == $past(flags, 2))
    else $error("port xor wrong");
  logic_flags_a: assert property (cmd_ok && op <= 4'hd && op != 4'h9 |-> ##2
    flags[3:1] == $past(flags[3:1], 2))
    else $error("logic op touched carry flags");
  zero_acc_a: assert property (cmd_ok && op inside {4'h0, 4'h1, 4'h3, 4'h4, 4'h6, 4'h7, 4'ha, 4'hc}
    |-> ##2 flags[0] == (work_register == 8'h00))
    else $error("zero flag wrong");
  not_acc_a: assert property (cmd_ok && op == 4'ha |-> ##2
    work_register == ~$past(work_register, 2))
    else $error("complement wrong");
  neg_acc_a: assert property (cmd_ok && op == 4'hc |-> ##2
    work_register == 8'h00 - $past(work_register, 2))
    else $error("negate wrong");
  mem_dest_a: assert property (cmd_ok && op inside {4'h2, 4'h5, 4'h8, 4'hb, 4'hd} |-> ##2
    mem_we && flags[0] == (mem_wdata == 8'h00) && work_register == $past(work_register, 2))
    else $error("memory write-back wrong");
  cmp_quiet_a: assert property (cmd_ok && op >= 4'he |-> ##2
    !mem_we && work_register == $past(work_register, 2))
    else $error("compare stored a result");
  mem_pulse_a: assert property (mem_we |=> !mem_we)
    else $error("write strobe too long");
endmodule
bind lca_top lca_top_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .work_register(work_register), .port_a_out_reg(port_a_out_reg), .flags(flags), .mem_wdata(mem_wdata),
  .mem_we(mem_we));

/* tb/lca_mem_model.sv */
// Purpose: data memory byte behind the slice
// Assumes: one operand location
// Notes: takes every write-back strobe
`timescale 1ns/1ps
module lca_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_byte
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      mem_byte <= 8'h00;
    else if (mem_we)
      mem_byte <= mem_wdata;
  end
endmodule

/* tb/lca_top_tb_top.sv */
// Purpose: self-checking bench for the logic and compare slice
// Assumes: zero-wait APB slave; results settle before the next access
// Notes: operand tables hold {op, work, operand, result}
`timescale 1ns/1ps
module lca_top_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, mem_we, er;
  logic [7:0] work_register, port_a_out_reg, mem_wdata, mem_byte;
  logic [3:0] flags;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  lca_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .work_register(work_register), .port_a_out_reg(port_a_out_reg), .flags(flags),
    .mem_wdata(mem_wdata), .mem_we(mem_we));
  lca_mem_model mem_u (.pclk(pclk), .presetn(presetn), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .mem_byte(mem_byte));
  always #10 pclk = ~pclk;
  task automatic give_verdict;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // a hang would otherwise stall the run silently
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic run_op(input logic [27:0] c, input logic [3:0] pf);
    apb(1'b1, lca_pkg::OFS_WORK, {24'h0, c[23:16]});
    apb(1'b1, lca_pkg::OFS_IMM, {24'h0, c[15:8]});
    apb(1'b1, lca_pkg::OFS_MEM_IN, {24'h0, c[15:8]});
    apb(1'b1, lca_pkg::OFS_FLAGS, {28'h0, pf});
    apb(1'b1, lca_pkg::OFS_CMD, {28'h0, c[27:24]});
  endtask
  task automatic t_bus;
    apb(1'b0, lca_pkg::OFS_WORK, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, lca_pkg::OFS_FLAGS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check({er, rd[30:0]}, 32'h80000000);
    apb(1'b1, lca_pkg::OFS_MEM_OUT, 32'h55);
    check({31'h0, er}, 32'h1);
  endtask
  task automatic t_acc;
    logic [27:0] tc [9] = '{28'h05a0f0a, 28'h15aa500, 28'h3380f3f, 28'h4000000, 28'h60f0f00,
      28'h738c7ff, 28'ha3800c7, 28'hc3800c8, 28'hc000000};
    logic z;
    for (int i = 0; i < 9; i++) begin
      z = (tc[i][7:0] == 8'h00);
      run_op(tc[i], {3'b111, ~z});
      apb(1'b0, lca_pkg::OFS_WORK, 32'h0);
      check(rd, {24'h0, tc[i][7:0]});
      apb(1'b0, lca_pkg::OFS_FLAGS, 32'h0);
      check(rd, {28'h0, 3'b111, z});
    end
  endtask
  task automatic t_mem;
    logic [27:0] tc [5] = '{28'h2384200, 28'h538427a, 28'h838427a, 28'hb0038c7, 28'hd0038c8};
    logic z;
    for (int i = 0; i < 5; i++) begin
      z = (tc[i][7:0] == 8'h00);
      run_op(tc[i], {3'b000, ~z});
      apb(1'b0, lca_pkg::OFS_MEM_OUT, 32'h0);
      check(rd, {24'h0, tc[i][7:0]});
      check({24'h0, mem_byte}, {24'h0, tc[i][7:0]});
      apb(1'b0, lca_pkg::OFS_WORK, 32'h0);
      check(rd, {24'h0, tc[i][23:16]});
      apb(1'b0, lca_pkg::OFS_FLAGS, 32'h0);
      check(rd, {28'h0, 3'b000, z});
    end
    // memory results leave the valid bit set until software clears it
    apb(1'b0, lca_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h2);
    apb(1'b1, lca_pkg::OFS_STATUS, 32'h2);
    apb(1'b0, lca_pkg::OFS_STATUS, 32'h0);
    check(rd, 32'h0);
  endtask
  task automatic t_io;
    apb(1'b1, lca_pkg::OFS_PORT, 32'h55);
    run_op(28'h90f0000, 4'h5);
    apb(1'b0, lca_pkg::OFS_PORT, 32'h0);
    check(rd, 32'h5a);
    check({24'h0, port_a_out_reg}, 32'h5a);
    apb(1'b0, lca_pkg::OFS_FLAGS, 32'h0);
    check(rd, 32'h5);
  endtask
  task automatic t_cmp;
    logic [27:0] tc [4] = '{28'he383801, 28'he384202, 28'hf384204, 28'he80010c};
    logic [7:0] m;
    for (int i = 0; i < 4; i++) begin
      m = mem_byte;
      run_op(tc[i], ~tc[i][3:0]);
      apb(1'b0, lca_pkg::OFS_FLAGS, 32'h0);
      check(rd, {28'h0, tc[i][3:0]});
      apb(1'b0, lca_pkg::OFS_WORK, 32'h0);
      check(rd, {24'h0, tc[i][23:16]});
      check({24'h0, mem_byte}, {24'h0, m});
    end
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_bus();
    t_acc();
    t_mem();
    t_io();
    t_cmp();
    give_verdict();
  end
endmodule
